// ### core/mesc_pkg.sv
// How it works
// RULE1 - Count each transmit frame abandoned after excessive collisions.
// RULE2 - Collision abort counter is 16 bits and wraps from 0xffff to zero.
// RULE3 - Collision abort counter reaching 0xc000 raises the statistics update event.
// RULE4 - Collision abort counter counts only when globally enabled and unmasked.
// RULE5 - Count received whole-octet frames whose check sequence fails.
// RULE6 - Too long or runt frames never count as check sequence errors.
// RULE7 - Check sequence error counter is 16 bits and wraps to zero.
// RULE8 - Check sequence error counter reaching 0xc000 raises the update event.
// RULE9 - Check sequence error counter counts only when enabled and unmasked.
// RULE10 - Count address-matched frames cut short by receive buffer overrun.
// RULE11 - Frames dropped because the buffer was full at start never count.
// RULE12 - Lost frame counter is 16 bits and wraps to zero.
// RULE13 - Lost frame counter reaching 0xc000 raises the update event.
// RULE14 - Lost frame counter counts only when enabled and unmasked.
// RULE15 - Counters sit at 0xfc, 0xcc, 0xce as 16-bit words, reset to zero.
// RULE16 - Reads return the live count; writes load it and counting continues.
package mesc_pkg;
    // ----------------------------------------
    // Counter geometry
    // ----------------------------------------
    localparam int          CNT_W        = 16;
    localparam int          NUM_CNT      = 3;
    localparam logic [15:0] CNT_RESET    = 16'h0000;
    localparam logic [15:0] CNT_THRESH   = 16'hc000;
    localparam logic [15:0] CNT_STEP     = 16'h0001;
    // ----------------------------------------
    // Counter indices and window offsets
    // ----------------------------------------
    localparam int          IDX_XCOL     = 0;
    localparam int          IDX_FCS      = 1;
    localparam int          IDX_LOST     = 2;
    localparam int          WIN_BITS     = 8;
    localparam logic [7:0]  OFS_XCOL     = 8'hfc;
    localparam logic [7:0]  OFS_FCS      = 8'hcc;
    localparam logic [7:0]  OFS_LOST     = 8'hce;
    localparam logic [15:0] RDATA_UNMAP  = 16'h0000;
endpackage : mesc_pkg

// ### core/mesc_cnt_if.sv
`timescale 1ns/10ps
interface mesc_cnt_if;
    logic        inc;
    logic        ld;
    logic [15:0] ld_val;
    logic [15:0] count;
    logic        reach;
    modport ctl (output inc, output ld, output ld_val, input count, input reach);
    modport cnt (input inc, input ld, input ld_val, output count, output reach);
endinterface : mesc_cnt_if

// ### core/mesc_counter.sv
`timescale 1ns/10ps
module mesc_counter (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Counter link
    mesc_cnt_if.cnt   bus
);
    typedef struct packed {
        logic [15:0] count;
        logic        reach;
    } mesc_cstate_t;

    mesc_cstate_t st;
    mesc_cstate_t next_st;
    logic [15:0]  bumped;

    // Natural 16-bit overflow gives the wrap to zero
    assign bumped = 16'(st.count + mesc_pkg::CNT_STEP); // RULE2 RULE7 RULE12

    always_comb begin
        next_st = st;
        next_st.reach = 1'b0;
        if (bus.ld) begin
            // Software load wins over a same-cycle event
            next_st.count = bus.ld_val; // RULE16
        end else if (bus.inc) begin
            next_st.count = bumped;
            next_st.reach = (bumped == mesc_pkg::CNT_THRESH); // RULE3 RULE8 RULE13
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '{count: mesc_pkg::CNT_RESET, reach: 1'b0}; // RULE15
        end else begin
            st <= next_st;
        end
    end

    assign bus.count = st.count;
    assign bus.reach = st.reach;

    chk_reach_cause : assert property (@(posedge clk) disable iff (!rstn) // RULE3
        bus.reach |-> (bus.count == mesc_pkg::CNT_THRESH) && $past(bus.inc))
        else $error("threshold pulse without reaching 0xc000");
endmodule : mesc_counter

// ### core/mesc_event_qual.sv
`timescale 1ns/10ps
module mesc_event_qual (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Enables
    input  wire logic       stats_global_enable,
    input  wire logic [2:0] stats_mask_reg,
    // MAC events
    input  wire logic       tx_abort_excess_coll,
    input  wire logic       rx_frame_end,
    input  wire logic       rx_fcs_bad,
    input  wire logic       rx_whole_octets,
    input  wire logic       rx_too_long,
    input  wire logic       rx_runt,
    input  wire logic       rx_overrun,
    input  wire logic       rx_addr_match,
    input  wire logic       rx_full_at_start,
    // Qualified increments
    output logic [2:0]      inc
);
    typedef struct packed {
        logic [2:0] inc;
    } mesc_qstate_t;

    mesc_qstate_t st;
    mesc_qstate_t next_st;
    logic [2:0]   raw;

    always_comb begin
        raw = 3'h0;
        raw[mesc_pkg::IDX_XCOL] = tx_abort_excess_coll; // RULE1
        raw[mesc_pkg::IDX_FCS]  = rx_frame_end && rx_fcs_bad && rx_whole_octets // RULE5
                                  && !rx_too_long && !rx_runt; // RULE6
        raw[mesc_pkg::IDX_LOST] = rx_overrun && rx_addr_match // RULE10
                                  && !rx_full_at_start; // RULE11
        next_st.inc = raw & ~stats_mask_reg & {3{stats_global_enable}}; // RULE4 RULE9 RULE14
    end

    // One register stage keeps the counters off the MAC's timing paths
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '{inc: 3'h0};
        end else begin
            st <= next_st;
        end
    end

    assign inc = st.inc;
endmodule : mesc_event_qual

// ### core/mesc_top.sv
`timescale 1ns/10ps
module mesc_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Register window access
    input  wire logic        acc_io,
    input  wire logic        acc_mem,
    input  wire logic        acc_wr,
    input  wire logic [31:0] acc_addr,
    input  wire logic [1:0]  acc_be,
    input  wire logic [15:0] acc_wdata,
    input  wire logic [31:0] io_window_base,
    input  wire logic [31:0] memory_window_base,
    output logic             acc_ack,
    output logic [15:0]      acc_rdata,
    // Statistics control
    input  wire logic        stats_global_enable,
    input  wire logic [2:0]  stats_mask_reg,
    // MAC events
    input  wire logic        tx_abort_excess_coll,
    input  wire logic        rx_frame_end,
    input  wire logic        rx_fcs_bad,
    input  wire logic        rx_whole_octets,
    input  wire logic        rx_too_long,
    input  wire logic        rx_runt,
    input  wire logic        rx_overrun,
    input  wire logic        rx_addr_match,
    input  wire logic        rx_full_at_start,
    // Interrupt status set
    output logic             stats_threshold_irq
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
    } mesc_tstate_t;

    mesc_tstate_t st;
    mesc_tstate_t next_st;

    logic [2:0]  qual_inc;
    logic [2:0]  ld;
    logic [2:0]  reach;
    logic [15:0] cnt [3];
    logic [15:0] ld_val [3];
    logic [31:0] io_ofs;
    logic [31:0] mem_ofs;
    logic        io_hit;
    logic        mem_hit;
    logic        hit;
    logic [7:0]  ofs;

    function automatic logic [7:0] mesc_offset_of(input int idx);
        unique case (idx)
            mesc_pkg::IDX_XCOL: mesc_offset_of = mesc_pkg::OFS_XCOL;
            mesc_pkg::IDX_FCS:  mesc_offset_of = mesc_pkg::OFS_FCS;
            default:            mesc_offset_of = mesc_pkg::OFS_LOST;
        endcase
    endfunction : mesc_offset_of

    // ----------------------------------------
    // Window decode
    // ----------------------------------------
    assign io_ofs  = acc_addr - io_window_base;
    assign mem_ofs = acc_addr - memory_window_base;
    assign io_hit  = acc_io && (io_ofs[31:mesc_pkg::WIN_BITS] == '0);
    assign mem_hit = acc_mem && (mem_ofs[31:mesc_pkg::WIN_BITS] == '0);
    assign hit     = io_hit || mem_hit;
    assign ofs     = io_hit ? io_ofs[7:0] : mem_ofs[7:0];

    // ----------------------------------------
    // Event qualification
    // ----------------------------------------
    mesc_event_qual u_qual (
        .clk                  (clk),
        .rstn                 (rstn),
        .stats_global_enable  (stats_global_enable),
        .stats_mask_reg       (stats_mask_reg),
        .tx_abort_excess_coll (tx_abort_excess_coll),
        .rx_frame_end         (rx_frame_end),
        .rx_fcs_bad           (rx_fcs_bad),
        .rx_whole_octets      (rx_whole_octets),
        .rx_too_long          (rx_too_long),
        .rx_runt              (rx_runt),
        .rx_overrun           (rx_overrun),
        .rx_addr_match        (rx_addr_match),
        .rx_full_at_start     (rx_full_at_start),
        .inc                  (qual_inc)
    );

    // ----------------------------------------
    // Counters
    // ----------------------------------------
    for (genvar g = 0; g < mesc_pkg::NUM_CNT; g++) begin : g_cnt
        mesc_cnt_if u_if ();

        // Byte lanes merge so a narrow write keeps the other half live
        assign ld[g]        = hit && acc_wr && (ofs == mesc_offset_of(g)) && (acc_be != 2'h0); // RULE16
        assign ld_val[g]    = {acc_be[1] ? acc_wdata[15:8] : cnt[g][15:8],
                               acc_be[0] ? acc_wdata[7:0]  : cnt[g][7:0]};
        assign u_if.inc     = qual_inc[g];
        assign u_if.ld      = ld[g];
        assign u_if.ld_val  = ld_val[g];
        assign cnt[g]       = u_if.count;
        assign reach[g]     = u_if.reach;

        mesc_counter u_counter (
            .clk  (clk),
            .rstn (rstn),
            .bus  (u_if.cnt)
        );

        chk_cnt_wrap : assert property (@(posedge clk) disable iff (!rstn) // RULE2 RULE7 RULE12
            qual_inc[g] && !ld[g] && (cnt[g] == 16'hffff) |=> (cnt[g] == 16'h0000))
            else $error("counter did not wrap to zero");

        chk_cnt_irq : assert property (@(posedge clk) disable iff (!rstn) // RULE3 RULE8 RULE13
            qual_inc[g] && !ld[g] && (cnt[g] == 16'hbfff) |=> stats_threshold_irq)
            else $error("no update event at 0xc000");

        chk_cnt_load : assert property (@(posedge clk) disable iff (!rstn) // RULE16
            ld[g] ##1 !ld[g] && !qual_inc[g] |-> (cnt[g] == $past(ld_val[g], 1)))
            else $error("written value not held");
    end

    assign stats_threshold_irq = |reach; // RULE3 RULE8 RULE13

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.ack = hit;
        if (hit && !acc_wr) begin
            unique case (ofs)
                mesc_pkg::OFS_XCOL: next_st.rdata = cnt[mesc_pkg::IDX_XCOL]; // RULE15
                mesc_pkg::OFS_FCS:  next_st.rdata = cnt[mesc_pkg::IDX_FCS];
                mesc_pkg::OFS_LOST: next_st.rdata = cnt[mesc_pkg::IDX_LOST];
                default:            next_st.rdata = mesc_pkg::RDATA_UNMAP;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '{ack: 1'b0, rdata: 16'h0000};
        end else begin
            st <= next_st;
        end
    end

    assign acc_ack   = st.ack;
    assign acc_rdata = st.rdata;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_xcol_count : assert property (@(posedge clk) disable iff (!rstn) // RULE1
        tx_abort_excess_coll && stats_global_enable && !stats_mask_reg[0]
        ##1 !ld[0] |=> (cnt[0] == 16'($past(cnt[0]) + 16'h0001)))
        else $error("abort not counted");

    chk_xcol_gate : assert property (@(posedge clk) disable iff (!rstn) // RULE4
        !(stats_global_enable && !stats_mask_reg[0]) ##1 !ld[0] |=> $stable(cnt[0]))
        else $error("abort counted while disabled");

    chk_fcs_count : assert property (@(posedge clk) disable iff (!rstn) // RULE5
        rx_frame_end && rx_fcs_bad && rx_whole_octets && !rx_too_long && !rx_runt
        && stats_global_enable && !stats_mask_reg[1]
        ##1 !ld[1] |=> (cnt[1] == 16'($past(cnt[1]) + 16'h0001)))
        else $error("check sequence error not counted");

    chk_fcs_size : assert property (@(posedge clk) disable iff (!rstn) // RULE6
        (rx_too_long || rx_runt) ##1 !ld[1] |=> $stable(cnt[1]))
        else $error("long or runt frame counted");

    chk_fcs_gate : assert property (@(posedge clk) disable iff (!rstn) // RULE9
        !(stats_global_enable && !stats_mask_reg[1]) ##1 !ld[1] |=> $stable(cnt[1]))
        else $error("check error counted while disabled");

    chk_lost_count : assert property (@(posedge clk) disable iff (!rstn) // RULE10
        rx_overrun && rx_addr_match && !rx_full_at_start
        && stats_global_enable && !stats_mask_reg[2]
        ##1 !ld[2] |=> (cnt[2] == 16'($past(cnt[2]) + 16'h0001)))
        else $error("overrun not counted");

    chk_lost_full : assert property (@(posedge clk) disable iff (!rstn) // RULE11
        rx_full_at_start ##1 !ld[2] |=> $stable(cnt[2]))
        else $error("frame ignored at full buffer counted");

    chk_lost_gate : assert property (@(posedge clk) disable iff (!rstn) // RULE14
        !(stats_global_enable && !stats_mask_reg[2]) ##1 !ld[2] |=> $stable(cnt[2]))
        else $error("overrun counted while disabled");

    chk_read_fcs : assert property (@(posedge clk) disable iff (!rstn) // RULE15
        hit && !acc_wr && (ofs == 8'hcc) |=> acc_ack && (acc_rdata == $past(cnt[1])))
        else $error("wrong read of check error counter");
endmodule : mesc_top

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    // ----------------------------------------
    // Signals and bench model
    // ----------------------------------------
    logic        clk, rstn, acc_io, acc_mem, acc_wr, acc_ack, stats_threshold_irq;
    logic [31:0] acc_addr, io_window_base, memory_window_base;
    logic [1:0]  acc_be;
    logic [15:0] acc_wdata, acc_rdata;
    logic        stats_global_enable, tx_abort_excess_coll, rx_frame_end, rx_fcs_bad;
    logic        rx_whole_octets, rx_too_long, rx_runt, rx_overrun, rx_addr_match;
    logic        rx_full_at_start;
    logic [2:0]  stats_mask_reg;
    logic [15:0] cnt [3];
    logic [7:0]  offs [3] = '{8'hfc, 8'hcc, 8'hce};
    logic [15:0] lfsr;
    int          n_mismatch, total_checks;

    mesc_top mesc_top_i (
        .clk(clk), .rstn(rstn), .acc_io(acc_io), .acc_mem(acc_mem), .acc_wr(acc_wr),
        .acc_addr(acc_addr), .acc_be(acc_be), .acc_wdata(acc_wdata),
        .io_window_base(io_window_base), .memory_window_base(memory_window_base),
        .acc_ack(acc_ack), .acc_rdata(acc_rdata), .stats_global_enable(stats_global_enable),
        .stats_mask_reg(stats_mask_reg), .tx_abort_excess_coll(tx_abort_excess_coll),
        .rx_frame_end(rx_frame_end), .rx_fcs_bad(rx_fcs_bad), .rx_whole_octets(rx_whole_octets),
        .rx_too_long(rx_too_long), .rx_runt(rx_runt), .rx_overrun(rx_overrun),
        .rx_addr_match(rx_addr_match), .rx_full_at_start(rx_full_at_start),
        .stats_threshold_irq(stats_threshold_irq)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic int slot(input logic [7:0] off);
        slot = 3;
        for (int i = 0; i < 3; i++) begin
            if (offs[i] == off) slot = i;
        end
    endfunction : slot

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One window access; the model predicts ack and read data before the strobe
    task automatic acc(input logic mem, input logic wr, input logic [31:0] addr,
                       input logic [1:0] be, input logic [15:0] wd);
        logic [31:0] rel;
        logic        hit;
        int          i;
        logic [15:0] exp;
        rel = addr - (mem ? memory_window_base : io_window_base);
        hit = rel < 32'h0000_0100;
        i = slot(rel[7:0]);
        exp = (i < 3) ? cnt[i] : 16'h0000;
        @(negedge clk);
        acc_io = !mem;
        acc_mem = mem;
        acc_wr = wr;
        acc_addr = addr;
        acc_be = be;
        acc_wdata = wd;
        // Ack stands only in the cycle after the taking edge
        @(negedge clk);
        chk({15'h0000, acc_ack}, {15'h0000, hit}, "ack");
        if (hit && !wr) chk(acc_rdata, exp, "read data");
        chk({15'h0000, stats_threshold_irq}, 16'h0000, "irq on access");
        acc_io = 1'b0;
        acc_mem = 1'b0;
        if (hit && wr && i < 3) begin
            cnt[i] = {be[1] ? wd[15:8] : cnt[i][15:8], be[0] ? wd[7:0] : cnt[i][7:0]};
        end
    endtask : acc

    task automatic rd_all(input logic mem);
        for (int i = 0; i < 3; i++) begin
            acc(mem, 1'b0, (mem ? memory_window_base : io_window_base) + offs[i], 2'h0, 16'h0000);
        end
    endtask : rd_all

    // One MAC event; r[5:0] carries the frame qualifiers
    task automatic ev(input int k, input logic [7:0] r, input logic en, input logic [2:0] m);
        logic q;
        q = en && !m[k] && (k == 0 || (k == 1 && r[0] && r[1] && !r[2] && !r[3])
            || (k == 2 && r[4] && !r[5]));
        @(negedge clk);
        stats_global_enable = en;
        stats_mask_reg = m;
        tx_abort_excess_coll = (k == 0);
        rx_frame_end = (k == 1);
        rx_overrun = (k == 2);
        {rx_full_at_start, rx_addr_match, rx_runt, rx_too_long, rx_whole_octets, rx_fcs_bad} = r[5:0];
        @(negedge clk);
        tx_abort_excess_coll = 1'b0;
        rx_frame_end = 1'b0;
        rx_overrun = 1'b0;
        // Count and threshold pulse land at the second edge after the event
        @(negedge clk);
        if (q) cnt[k] = cnt[k] + 16'h0001;
        chk({15'h0000, stats_threshold_irq}, {15'h0000, q && cnt[k] == 16'hc000}, "irq");
    endtask : ev

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {acc_io, acc_mem, acc_wr, acc_be, acc_wdata, acc_addr} = '0;
        {stats_global_enable, stats_mask_reg, tx_abort_excess_coll, rx_frame_end} = '0;
        {rx_fcs_bad, rx_whole_octets, rx_too_long, rx_runt, rx_overrun} = '0;
        {rx_addr_match, rx_full_at_start} = '0;
        io_window_base = 32'h0000_1000;
        memory_window_base = 32'h8000_0000;
        cnt = '{16'h0000, 16'h0000, 16'h0000};
        lfsr = 16'h003c;
        rstn = 1'b0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        rd_all(1'b0);
        acc(1'b1, 1'b1, memory_window_base + 32'h0000_00d0, 2'h3, 16'hffff);
        acc(1'b0, 1'b0, io_window_base + 32'h0000_00d0, 2'h0, 16'h0000);
        acc(1'b0, 1'b0, io_window_base + 32'h0000_0100, 2'h0, 16'h0000);
        acc(1'b1, 1'b1, memory_window_base - 32'h0000_0004, 2'h3, 16'h5555);
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, 1'b1, memory_window_base + offs[i], 2'h3, 16'h1234 + 16'(i));
            acc(1'b1, 1'b1, memory_window_base + offs[i], 2'h1, 16'h77ab);
            acc(1'b0, 1'b1, io_window_base + offs[i], 2'h0, 16'hffff);
            rd_all(1'b0);
            // Loading the threshold value must not raise the update pulse
            acc(1'b0, 1'b1, io_window_base + offs[i], 2'h3, 16'hc000);
            // Wrap from all ones, then step into and past the threshold
            acc(1'b0, 1'b1, io_window_base + offs[i], 2'h3, 16'hffff);
            ev(i, 8'h13, 1'b1, 3'h0);
            acc(1'b0, 1'b1, io_window_base + offs[i], 2'h3, 16'hbfff);
            ev(i, 8'h13, 1'b1, 3'h0);
            ev(i, 8'h13, 1'b1, 3'h0);
            rd_all(1'b1);
        end
        // Random events; biased so that good frames are common enough to count
        repeat (300) begin
            lfsr = lfsr_next(lfsr);
            ev(int'(lfsr[9:8]) % 3, lfsr[4] ? 8'h13 : lfsr[7:0], lfsr[10] | lfsr[11],
               lfsr[12] ? lfsr[15:13] : 3'h0);
            rd_all(lfsr[5]);
        end
        // Reset in mid-run must clear every counter
        @(negedge clk);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        cnt = '{16'h0000, 16'h0000, 16'h0000};
        rd_all(1'b0);
        report_and_stop;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop;
    end
endmodule : testbench
